// *** dv/frfc_fault_unit_assertions.sv ***
/* Port-level checks for the fault return and fault control unit.
   Assumes it is bound into frfc_fault_unit and sees its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "frfc_map.vh"
module frfc_fault_unit_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cond_valid,
  input wire logic [4:0]  cond_class,
  input wire logic        cond_before_exec,
  input wire logic [1:0]  entry_type,
  input wire logic [31:0] ovf_result,
  input wire logic        handler_ret,
  input wire logic        fault_taken,
  input wire logic        fault_via_system,
  input wire logic        cond_complete,
  input wire logic        dest_write,
  input wire logic [31:0] dest_data,
  input wire logic        state_commit,
  input wire logic        resume_go,
  input wire logic [31:0] resume_ip
);
  // ---------------------------------------------------------------
  // Core side checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Overflow result lands one cycle after its condition
  a_ovf_dest: assert property (
    dest_write |-> $past(cond_valid) && dest_data == $past(ovf_result)
    && $past(cond_class) == `FRFC_F_INT_OVF)
    else $error("destination write without an overflow cause");
  // Each condition ends in exactly one of fault or completion
  a_one_outcome: assert property (
    cond_valid |=> fault_taken != cond_complete)
    else $error("condition gave no single outcome");
  a_masked_quiet: assert property (
    cond_complete |-> !fault_taken && !fault_via_system)
    else $error("masked condition raised a fault");
  a_system_entry: assert property (
    cond_valid |=> fault_via_system
      == (fault_taken && $past(entry_type) == `FRFC_ENT_SYSTEM))
    else $error("system entry flag wrong");
  a_pre_exec_hold: assert property (
    cond_valid && cond_before_exec ##1 fault_taken |-> !state_commit)
    else $error("pre-execution fault committed state");
  // A return resumes or refaults, never both, never neither
  a_ret_outcome: assert property (
    handler_ret |=> resume_go != fault_taken)
    else $error("handler return gave no single outcome");
  a_resume_cause: assert property (
    resume_go |-> $past(handler_ret))
    else $error("resumption without a handler return");
  // Pointer must not drift, or the core would resume at a stale place
  a_ip_hold: assert property (
    !$past(handler_ret) |-> $stable(resume_ip))
    else $error("resume pointer moved without a return");

  c_masked: cover property (cond_complete);
  c_system: cover property (fault_via_system);
  c_overflow: cover property (dest_write);
  c_refault: cover property (handler_ret ##1 fault_taken);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
/* Self-checking bench for the fault unit: APB master, core strobes and
   a small model. Assumes frfc_map.vh and the checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
`include "frfc_map.vh"
module testbench;
  logic        clock = 0;
  logic        rst = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, cond_fault_ip = 0, cond_next_ip = 0;
  logic [31:0] ovf_result = 0, rd, v, arith, proc;
  logic        cond_valid = 0, cond_before_exec = 0, cond_imprecise = 0;
  logic        handler_ret = 0, err, msk;
  logic [4:0]  cond_class = 0;
  logic [7:0]  cond_trace_mode = 0;
  logic [1:0]  entry_type = 0;
  wire  [31:0] prdata, dest_data, resume_ip;
  wire         pready, pslverr, fault_taken, fault_via_system, dest_write;
  wire         cond_complete, state_commit, sync_barrier, resume_go;
  wire         resume_suspended, irq;
  int          error_cnt = 0, comparisons = 0, i, k;

  frfc_fault_unit frfc_fault_unit_i (.clock, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cond_valid,
    .cond_class, .cond_before_exec, .cond_imprecise, .cond_trace_mode,
    .cond_fault_ip, .cond_next_ip, .entry_type, .ovf_result, .handler_ret,
    .fault_taken, .fault_via_system, .cond_complete, .dest_write,
    .dest_data, .state_commit, .sync_barrier, .resume_go, .resume_ip,
    .resume_suspended, .irq);

  always #2 clock = ~clock;

  // ---------------------------------------------------------------
  // Tasks and model
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock) begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
    end
    @(posedge clock) penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      error_cnt++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // One-cycle condition (r=0) or handler return (r=1); ends off-edge
  task automatic strobe(input logic r);
    @(posedge clock) begin
      cond_valid <= !r;
      handler_ret <= r;
    end
    @(posedge clock) begin
      cond_valid <= 0;
      handler_ret <= 0;
    end
    #1;
  endtask

  // FP classes sit one code above their mask bit
  function automatic logic masked();
    if (cond_class == `FRFC_F_INT_OVF) masked = arith[0];
    else if (cond_class >= `FRFC_F_FP_OVF && cond_class <= `FRFC_F_FP_INEX)
      masked = arith[cond_class - 1];
    else masked = cond_class == `FRFC_F_TRACE
      && !(proc[1] && cond_trace_mode[3:0] != 0);
  endfunction

  initial begin
    i = $urandom(32);
    repeat (10) @(posedge clock);
    rst <= 0;
    apb(0, `FRFC_OFF_ARITH, 0);
    chk("ac_rst", rd, `FRFC_AC_RESET);
    apb(0, `FRFC_OFF_PROC, 0);
    chk("pc_rst", rd, `FRFC_PC_RESET);
    apb(1, 12'h040, 32'hffffffff);
    chk("unmap_w", err, 1);
    apb(0, 12'h040, 0);
    chk("unmap_r", rd, 0);
    apb(1, `FRFC_OFF_TRACE, 32'h0000000f);
    apb(1, `FRFC_OFF_MASK, 32'h00000001);
    // Every class, random masks, modes and entry kinds
    for (i = 0; i < 54; i++) begin
      arith = {25'h0, 7'($urandom)};
      proc = {30'h0, 1'($urandom), 1'b1};
      apb(1, `FRFC_OFF_ARITH, arith);
      apb(1, `FRFC_OFF_PROC, proc);
      v = $urandom & 32'hfffffffc;
      cond_class <= 5'(i % 18);
      cond_before_exec <= 1'($urandom);
      cond_imprecise <= 1'($urandom);
      cond_trace_mode <= 8'($urandom);
      entry_type <= {1'($urandom), 1'b0};
      cond_fault_ip <= v;
      cond_next_ip <= v + 4;
      ovf_result <= $urandom;
      strobe(0);
      msk = masked();
      chk("taken", fault_taken, !msk);
      chk("done", cond_complete, msk);
      chk("sys", fault_via_system, !msk && entry_type[1]);
      if (!msk) chk("sync", sync_barrier, cond_imprecise && arith[6]);
      chk("commit", state_commit, msk || !cond_before_exec);
      if (!msk && cond_class == `FRFC_F_INT_OVF)
        chk("dest", dest_write ? dest_data : ~ovf_result, ovf_result);
      apb(0, `FRFC_OFF_STATUS, 0);
      chk("status", rd[1:0], msk ? 2'b10 : 2'b01);
      chk("irq", irq, !msk);
      apb(1, `FRFC_OFF_STATUS, 32'h0000000f);
      #1;
      chk("irq_clr", irq, 0);
      if (!msk) begin
        apb(0, `FRFC_OFF_FTYPE, 0);
        chk("ftype", rd, {26'h0, entry_type[1], cond_class});
        apb(0, `FRFC_OFF_SAVEDPC, 0);
        chk("resume", rd[3], cond_before_exec && cond_class != 5'h06
          && cond_class <= `FRFC_F_EVENT);
        strobe(1);
        chk("go", resume_go, 1);
        chk("susp", resume_suspended, entry_type[1] && rd[3]);
        if (!entry_type[1]) chk("rip", resume_ip === cond_fault_ip
          || resume_ip === cond_next_ip, 1);
      end
    end
    // Altered return pointer after a post-execution local fault;
    // handler scrubs resume, trace-pending and internal state first
    @(posedge clock);
    cond_class <= `FRFC_F_VMEM;
    cond_before_exec <= 0;
    entry_type <= `FRFC_ENT_LOCAL;
    strobe(0);
    apb(0, `FRFC_OFF_SAVEDPC, 0);
    apb(1, `FRFC_OFF_SAVEDPC, rd & 32'hffff00e7);
    apb(1, `FRFC_OFF_RETPTR, 32'h00001230);
    strobe(1);
    chk("rip_alt", resume_ip, 32'h00001230);
    chk("alt_susp", resume_suspended, 0);
    // Saved controls come back only in supervisor mode
    @(posedge clock);
    entry_type <= `FRFC_ENT_SYSTEM;
    for (i = 0; i < 2; i++) begin
      strobe(0);
      apb(1, `FRFC_OFF_PROC, {31'h0, i == 0});
      apb(1, `FRFC_OFF_SAVEDPC, 32'h00000003);
      strobe(1);
      apb(0, `FRFC_OFF_PROC, 0);
      chk("restore", rd[1], i == 0);
    end
    // Refault on return, then interrupt masking
    strobe(0);
    apb(1, `FRFC_OFF_PROC, 32'h00000005);
    strobe(1);
    chk("refault", {fault_taken, resume_go}, 2'b10);
    apb(0, `FRFC_OFF_PROC, 0);
    chk("rf_clr", rd[2], 0);
    apb(0, `FRFC_OFF_STATUS, 0);
    chk("rf_st", rd[3], 1);
    chk("irq_on", irq, 1);
    apb(1, `FRFC_OFF_MASK, 0);
    #1;
    chk("irq_mask", irq, 0);
    print_verdict();
  end
endmodule

bind frfc_fault_unit frfc_fault_unit_assertions chk_i (.clock, .rst,
  .cond_valid, .cond_class, .cond_before_exec, .entry_type, .ovf_result,
  .handler_ret, .fault_taken, .fault_via_system, .cond_complete,
  .dest_write, .dest_data, .state_commit, .resume_go, .resume_ip);
`default_nettype wire

// *** include/frfc_map.vh ***
/*
 * Register offsets, field positions and reset values for the fault
 * return and fault control block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`ifndef FRFC_MAP_VH
`define FRFC_MAP_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define FRFC_OFF_ARITH     12'h000
`define FRFC_OFF_PROC      12'h004
`define FRFC_OFF_TRACE     12'h008
`define FRFC_OFF_STATUS    12'h00c
`define FRFC_OFF_MASK      12'h010
`define FRFC_OFF_SAVEDPC   12'h014
`define FRFC_OFF_RETPTR    12'h018
`define FRFC_OFF_FTYPE     12'h01c
`define FRFC_OFF_RESUMEIP  12'h020

// -----------------------------------------------------------------
// Arithmetic control fields (fault mask bits, imprecise flag)
// -----------------------------------------------------------------
`define FRFC_AC_INT_OVF    0
`define FRFC_AC_FP_OVF     1
`define FRFC_AC_FP_UNF     2
`define FRFC_AC_FP_INV     3
`define FRFC_AC_FP_ZDIV    4
`define FRFC_AC_FP_INEX    5
`define FRFC_AC_NIF        6
`define FRFC_AC_RESET      32'h00000040

// -----------------------------------------------------------------
// Process control fields
// -----------------------------------------------------------------
`define FRFC_PC_SUPER      0
`define FRFC_PC_TRACE_EN   1
`define FRFC_PC_REFAULT    2
`define FRFC_PC_RESUME     3
`define FRFC_PC_TFPEND     4
`define FRFC_PC_ISTATE_LO  8
`define FRFC_PC_ISTATE_HI  15
`define FRFC_PC_RESET      32'h00000001

// -----------------------------------------------------------------
// Fault class codes on the core fault port
// -----------------------------------------------------------------
`define FRFC_F_OPER        5'h00
`define FRFC_F_ARITH_ZDIV  5'h01
`define FRFC_F_FP_OVF      5'h02
`define FRFC_F_FP_UNF      5'h03
`define FRFC_F_FP_INV      5'h04
`define FRFC_F_FP_ZDIV     5'h05
`define FRFC_F_FP_INEX     5'h06
`define FRFC_F_CONSTR      5'h07
`define FRFC_F_TRACE       5'h08
`define FRFC_F_INV_DESC    5'h09
`define FRFC_F_VMEM        5'h0a
`define FRFC_F_TSLICE      5'h0b
`define FRFC_F_EVENT       5'h0c
`define FRFC_F_INT_OVF     5'h0d
`define FRFC_F_STRUCT      5'h0e
`define FRFC_F_BADACC      5'h0f
`define FRFC_F_PROT        5'h10
`define FRFC_F_TYPE        5'h11

// -----------------------------------------------------------------
// Fault table entry types and status bits
// -----------------------------------------------------------------
`define FRFC_ENT_LOCAL     2'h0
`define FRFC_ENT_SYSTEM    2'h2
`define FRFC_ST_FAULT      0
`define FRFC_ST_MASKED     1
`define FRFC_ST_RETURN     2
`define FRFC_ST_REFAULT    3
`define FRFC_ST_WIDTH      4

`endif

// *** verilog/frfc_fault_unit.v ***
/*
 * Fault return and fault control unit: gates fault conditions by the
 * arithmetic masks and trace enable, captures the fault record, and
 * decides how work resumes when the handler returns.
 * Assumes the core drives single-cycle fault and return strobes and
 * an APB master on the same 250 MHz clock.
 */
// Chosen here: the APB interface to the registers and the register offsets.
// What this block does
// - Handler return starts resumption automatically
// - Restore saved controls only in supervisor mode
// - Local-call entry resumes at saved return pointer
// - Return pointer is faulting or next instruction
// - Pre-execution fault leaves process state untouched
// - Integer overflow writes result in the same cycle as the fault
// - Listed fault classes are resumable
// - Listed fault classes may not resume
// - Resume flag set when resumption info collected
// - Altered return with resume set is undefined
// - Arithmetic mask bits suppress matching faults
// - Imprecise flag governs fault synchronisation
// - Refault flag raises fault on return
// - Trace faults need trace enable and mode
// - Entry type 10 enters via system call
`timescale 1ns/1ps
`default_nettype none
`include "frfc_map.vh"

module frfc_fault_unit #(
  parameter AW = 12
) (
  input  wire        clock,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Core fault condition port
  input  wire        cond_valid,
  input  wire [4:0]  cond_class,
  input  wire        cond_before_exec,
  input  wire        cond_imprecise,
  input  wire [7:0]  cond_trace_mode,
  input  wire [31:0] cond_fault_ip,
  input  wire [31:0] cond_next_ip,
  input  wire [1:0]  entry_type,
  input  wire [31:0] ovf_result,
  // Handler return strobe
  input  wire        handler_ret,
  // Outputs to the core
  output reg         fault_taken,
  output reg         fault_via_system,
  output reg         cond_complete,
  output reg         dest_write,
  output reg  [31:0] dest_data,
  output reg         state_commit,
  output reg         sync_barrier,
  output reg         resume_go,
  output reg  [31:0] resume_ip,
  output reg         resume_suspended,
  output wire        irq
);

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  reg [31:0] arith_ctrl;
  reg [31:0] process_ctrl;
  reg [7:0]  trace_ctrl;
  reg [`FRFC_ST_WIDTH-1:0] status;
  reg [`FRFC_ST_WIDTH-1:0] mask;
  reg [31:0] saved_pc;
  reg [31:0] return_pointer_register;
  reg [4:0]  saved_class;
  reg        entered_system;
  reg [31:0] read_mux;
  reg [`FRFC_ST_WIDTH-1:0] next_status;

  // Mask bit in arithmetic controls that gates a class, or none
  function masked_by;
    input [4:0]  cls;
    input [31:0] ac;
    begin
      case (cls)
        `FRFC_F_INT_OVF: masked_by = ac[`FRFC_AC_INT_OVF];
        `FRFC_F_FP_OVF:  masked_by = ac[`FRFC_AC_FP_OVF];
        `FRFC_F_FP_UNF:  masked_by = ac[`FRFC_AC_FP_UNF];
        `FRFC_F_FP_INV:  masked_by = ac[`FRFC_AC_FP_INV];
        `FRFC_F_FP_ZDIV: masked_by = ac[`FRFC_AC_FP_ZDIV];
        `FRFC_F_FP_INEX: masked_by = ac[`FRFC_AC_FP_INEX];
        default:         masked_by = 1'b0;
      endcase
    end
  endfunction

  // Classes that leave the process resumable when faulted before execution
  function resumable;
    input [4:0] cls;
    begin
      case (cls)
        `FRFC_F_OPER, `FRFC_F_ARITH_ZDIV, `FRFC_F_FP_OVF,
        `FRFC_F_FP_UNF, `FRFC_F_FP_INV, `FRFC_F_FP_ZDIV,
        `FRFC_F_CONSTR, `FRFC_F_TRACE, `FRFC_F_INV_DESC,
        `FRFC_F_VMEM, `FRFC_F_TSLICE, `FRFC_F_EVENT:
          resumable = 1'b1;
        default:
          resumable = 1'b0;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // Fault qualification
  // -----------------------------------------------------------------
  wire is_trace   = (cond_class == `FRFC_F_TRACE);
  wire trace_ok   = process_ctrl[`FRFC_PC_TRACE_EN] &
                    (|(cond_trace_mode & trace_ctrl));
  wire cond_mask  = masked_by(cond_class, arith_ctrl) |
                    (is_trace & ~trace_ok);
  wire raise      = cond_valid & ~cond_mask;
  wire refault_go = handler_ret & process_ctrl[`FRFC_PC_REFAULT];
  wire do_raise   = raise | refault_go;
  wire super_now  = process_ctrl[`FRFC_PC_SUPER];

  // APB decode; zero wait states, unmapped reads zero with error
  wire apb_acc = psel & penable;
  wire apb_wr  = apb_acc & pwrite;
  reg  hit;
  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit;
  assign irq     = |(status & mask);

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  always @* begin
    hit      = 1'b1;
    read_mux = 32'h00000000;
    case (paddr)
      `FRFC_OFF_ARITH:    read_mux = arith_ctrl;
      `FRFC_OFF_PROC:     read_mux = process_ctrl;
      `FRFC_OFF_TRACE:    read_mux = {24'h000000, trace_ctrl};
      `FRFC_OFF_STATUS:   read_mux = {28'h0000000, status};
      `FRFC_OFF_MASK:     read_mux = {28'h0000000, mask};
      `FRFC_OFF_SAVEDPC:  read_mux = saved_pc;
      `FRFC_OFF_RETPTR:   read_mux = return_pointer_register;
      `FRFC_OFF_FTYPE:    read_mux = {26'h0, entered_system,
                                      saved_class};
      `FRFC_OFF_RESUMEIP: read_mux = resume_ip;
      default:            hit = 1'b0;
    endcase
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always @* begin
    next_status = status;
    if (apb_wr && paddr == `FRFC_OFF_STATUS) begin
      next_status = status & ~pwdata[`FRFC_ST_WIDTH-1:0];
    end
    if (do_raise) begin
      next_status[`FRFC_ST_FAULT] = 1'b1;
    end
    if (cond_valid & cond_mask) begin
      next_status[`FRFC_ST_MASKED] = 1'b1;
    end
    if (handler_ret) begin
      next_status[`FRFC_ST_RETURN] = 1'b1;
    end
    if (refault_go) begin
      next_status[`FRFC_ST_REFAULT] = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Control state, fault record and return handling
  // -----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      arith_ctrl              <= `FRFC_AC_RESET;
      process_ctrl            <= `FRFC_PC_RESET;
      trace_ctrl              <= 8'h00;
      status                  <= {`FRFC_ST_WIDTH{1'b0}};
      mask                    <= {`FRFC_ST_WIDTH{1'b0}};
      saved_pc                <= 32'h00000000;
      return_pointer_register <= 32'h00000000;
      saved_class             <= 5'h00;
      entered_system          <= 1'b0;
      prdata                  <= 32'h00000000;
      fault_taken             <= 1'b0;
      fault_via_system        <= 1'b0;
      cond_complete           <= 1'b0;
      dest_write              <= 1'b0;
      dest_data               <= 32'h00000000;
      state_commit            <= 1'b0;
      sync_barrier            <= 1'b0;
      resume_go               <= 1'b0;
      resume_ip               <= 32'h00000000;
      resume_suspended        <= 1'b0;
    end else begin
      status           <= next_status;
      // Read data is latched in the setup phase so it leaves a flop;
      // a register that changes during the access shows its old value
      if (psel & ~penable) begin
        prdata <= read_mux;
      end
      fault_taken      <= do_raise;
      fault_via_system <= do_raise & (entry_type == `FRFC_ENT_SYSTEM);
      // Masked conditions finish the instruction, no record written
      cond_complete    <= cond_valid & cond_mask;
      // Overflowed value lands in the destination even when faulting
      dest_write       <= cond_valid & (cond_class == `FRFC_F_INT_OVF);
      dest_data        <= ovf_result;
      // A fault before execution must not commit any process state
      state_commit     <= cond_valid & ~(raise & cond_before_exec);
      // Imprecise faults are fenced only while the flag is set
      sync_barrier     <= cond_valid & cond_imprecise &
                          arith_ctrl[`FRFC_AC_NIF];
      resume_go        <= handler_ret & ~refault_go;
      if (apb_wr) begin
        case (paddr)
          `FRFC_OFF_ARITH:   arith_ctrl <= pwdata;
          `FRFC_OFF_PROC:    process_ctrl <= pwdata;
          `FRFC_OFF_TRACE:   trace_ctrl <= pwdata[7:0];
          `FRFC_OFF_MASK:    mask <= pwdata[`FRFC_ST_WIDTH-1:0];
          // Handler software edits the saved controls here; a changed
          // return point with resume still set is left undefined
          `FRFC_OFF_SAVEDPC: saved_pc <= pwdata;
          `FRFC_OFF_RETPTR:  return_pointer_register <= pwdata;
          default: ;
        endcase
      end
      if (raise) begin
        saved_class    <= cond_class;
        entered_system <= (entry_type == `FRFC_ENT_SYSTEM);
        // Saved return pointer is the faulting or next instruction
        return_pointer_register <= cond_before_exec ? cond_fault_ip
                                                    : cond_next_ip;
        // Resume flag marks that resumption info was collected
        saved_pc <= process_ctrl | ((resumable(cond_class) &
                    cond_before_exec) ? (32'h1 << `FRFC_PC_RESUME)
                                       : 32'h0);
        if (entry_type == `FRFC_ENT_SYSTEM) begin
          process_ctrl[`FRFC_PC_SUPER] <= 1'b1;
        end
        if (is_trace) begin
          process_ctrl[`FRFC_PC_TRACE_EN] <= 1'b0;
        end
      end
      if (handler_ret & ~refault_go) begin
        if (entered_system & super_now) begin
          // Supervisor return restores the saved controls
          process_ctrl <= saved_pc;
          resume_suspended <= saved_pc[`FRFC_PC_RESUME];
        end else begin
          // Local entry, or a system entry returned outside supervisor mode, ignores the resumption record
          resume_suspended <= 1'b0;
        end
        resume_ip <= return_pointer_register;
      end
      // Flag is consumed by the fault it raises, so it fires once
      if (refault_go) begin
        process_ctrl[`FRFC_PC_REFAULT] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire
